// File: hw/sdf_defines.svh
// Constants for the third-order sinc decimation filter.
// Assumes inclusion by bare name from the package and the filter module.
// What this block does
// [R1] Three cascaded running sums, one result per period
// [R2] Ratio selectable from 16 to 256
// [R3] Default ratio 256, 16-bit output word
// [R4] Word rate is modulator clock over ratio
// [R5] Response -3 dB at quarter word rate
// [R6] Optional cascade with later higher-order stage
// [R7] First integrator counts incoming one bits
// [R8] Second and third integrators accumulate previous stage
// [R9] Reset clears all integrators and delays
// [R10] Strobe captures, shifts delays, three subtractions
// [R11] Internal words 24 bits, unsigned wrap-around
// [R12] Third order settles after three updates
// [R13] Fast variant: second order times delayed sum
// [R14] Signal delay is half settling time
// [R15] Modulator clock and bit wired directly
// [R16] Modulator changes bit on falling edge
// [R17] Ones density encodes input level
// [R18] Strobe pulses once per ratio clocks
`ifndef SDF_DEFINES_SVH
`define SDF_DEFINES_SVH
`define SDF_WORD_WIDTH 24
`define SDF_OUT_WIDTH 16
`define SDF_RATIO_MIN 16
`define SDF_RATIO_MAX 256
`define SDF_RATIO_DEFAULT 256
`define SDF_RATIO_CNT_WIDTH 9
`define SDF_ORDER_THIRD 1'h0
`define SDF_ORDER_FAST 1'h1
`define SDF_SETTLE_THIRD 2'h3
`define SDF_SETTLE_FAST 2'h3
`endif

// File: hw/sdf_pkg.sv
// Types shared by the sinc decimation filter.
// Assumes sdf_defines.svh is reachable by bare name.
`include "sdf_defines.svh"
package sdf_pkg;
  typedef logic [`SDF_WORD_WIDTH-1:0] sdf_word_type;
  typedef enum logic [1:0] {
    SDF_ORDER3 = 2'h0,
    SDF_ORDER2 = 2'h1
  } sdf_mode_type;
  typedef struct packed {
    sdf_word_type filtered_word;
    logic [`SDF_OUT_WIDTH-1:0] short_word;
    logic settled;
    logic valid;
  } sdf_result_type;
endpackage

// File: hw/sdf_filter.sv
// Sinc decimation filter on the modulator bitstream.
// Assumes clk_i is the modulator clock and the bit changes on its fall.
// Either reset clears every register; one result leaves per ratio clocks.
// Mode and ratio are held static between resets.
`timescale 1ns/1ps
`include "sdf_defines.svh"
module sdf_filter #(
  parameter int RATIO = `SDF_RATIO_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic async_reset_low_i,
  input wire logic modulator_bit_in_i,
  input wire logic fast_mode_i,
  input wire logic [`SDF_RATIO_CNT_WIDTH-1:0] oversampling_ratio_i,
  output sdf_pkg::sdf_result_type result_o,
  output logic decimation_strobe_o
);
  ////////////////////////////////////////////////////////////////////////
  // Ratio select and decimation strobe
  logic [`SDF_RATIO_CNT_WIDTH-1:0] ratio_eff;
  logic [`SDF_RATIO_CNT_WIDTH-1:0] ratio_cnt;
  logic [`SDF_RATIO_CNT_WIDTH-1:0] next_ratio_cnt;
  logic decimation_strobe;

  always_comb begin
    if (oversampling_ratio_i < `SDF_RATIO_CNT_WIDTH'(`SDF_RATIO_MIN) ||
        oversampling_ratio_i > `SDF_RATIO_CNT_WIDTH'(`SDF_RATIO_MAX)) begin
      ratio_eff = `SDF_RATIO_CNT_WIDTH'(RATIO); // R2 R3
    end else begin
      ratio_eff = oversampling_ratio_i; // R2 R6
    end
  end

  assign decimation_strobe = (ratio_cnt == ratio_eff - 1'b1); // R18 R4
  assign next_ratio_cnt = decimation_strobe ? '0 : ratio_cnt + 1'b1;

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      ratio_cnt <= '0;
    end else if (!rst_b_i) begin
      ratio_cnt <= '0;
    end else begin
      ratio_cnt <= next_ratio_cnt; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Integrators on every modulator clock
  sdf_pkg::sdf_word_type first_integrator;
  sdf_pkg::sdf_word_type second_integrator;
  sdf_pkg::sdf_word_type third_integrator;

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      first_integrator <= '0; // R9
    end else if (!rst_b_i) begin
      first_integrator <= '0;
    end else if (modulator_bit_in_i) begin
      first_integrator <= first_integrator + 1'b1; // R7 R11
    end
  end

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      second_integrator <= '0; // R9
    end else if (!rst_b_i) begin
      second_integrator <= '0;
    end else begin
      second_integrator <= second_integrator + first_integrator; // R8
    end
  end

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      third_integrator <= '0; // R9
    end else if (!rst_b_i) begin
      third_integrator <= '0;
    end else begin
      third_integrator <= third_integrator + second_integrator; // R8 R1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comb stages on the decimation strobe
  sdf_pkg::sdf_word_type comb_capture;
  sdf_pkg::sdf_word_type comb_delay_a;
  sdf_pkg::sdf_word_type comb_delay_b;
  sdf_pkg::sdf_word_type comb_delay_c;
  sdf_pkg::sdf_word_type comb_stage_one;
  sdf_pkg::sdf_word_type comb_stage_two;
  sdf_pkg::sdf_word_type comb_stage_three;
  sdf_pkg::sdf_word_type fast_delay_a;
  sdf_pkg::sdf_word_type fast_delay_b;
  sdf_pkg::sdf_word_type comb_src;

  // Fast mode takes the second-order sum so the comb chain is one short
  assign comb_src = fast_mode_i ? second_integrator : third_integrator;
  assign comb_stage_one = comb_capture - comb_delay_a; // R10
  assign comb_stage_two = comb_stage_one - comb_delay_b; // R10
  assign comb_stage_three = comb_stage_two - comb_delay_c; // R10 R11 R5

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      comb_capture <= '0; // R9
      comb_delay_a <= '0; // R9
    end else if (!rst_b_i) begin
      comb_capture <= '0;
      comb_delay_a <= '0;
    end else if (decimation_strobe) begin
      comb_capture <= comb_src; // R10
      comb_delay_a <= comb_capture; // R10
    end
  end

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      comb_delay_b <= '0; // R9
      comb_delay_c <= '0; // R9
    end else if (!rst_b_i) begin
      comb_delay_b <= '0;
      comb_delay_c <= '0;
    end else if (decimation_strobe) begin
      comb_delay_b <= comb_stage_one; // R10
      comb_delay_c <= comb_stage_two; // R10
    end
  end

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      fast_delay_a <= '0;
      fast_delay_b <= '0;
    end else if (!rst_b_i) begin
      fast_delay_a <= '0;
      fast_delay_b <= '0;
    end else if (decimation_strobe) begin
      fast_delay_a <= comb_stage_two; // R13
      fast_delay_b <= fast_delay_a; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output word, valid pulse and settling count
  sdf_pkg::sdf_word_type word_sel;
  logic [1:0] settle_cnt;
  logic strobe_d;
  logic [1:0] settle_goal;
  logic out_valid;
  logic out_settled;
  sdf_pkg::sdf_word_type out_word;
  logic [`SDF_OUT_WIDTH-1:0] out_short;

  // Both orders count a fixed number of updates before settling
  assign settle_goal = fast_mode_i ? `SDF_SETTLE_FAST
                                   : `SDF_SETTLE_THIRD; // R12

  // Sinc2 times (1 + z^-2 ratio): add the sinc2 word two periods back
  assign word_sel = fast_mode_i ? comb_stage_two + fast_delay_b // R13
                                : comb_stage_three; // R1

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      strobe_d <= 1'b0;
    end else if (!rst_b_i) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= decimation_strobe;
    end
  end

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      out_valid <= 1'b0; // R9
    end else if (!rst_b_i) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= strobe_d; // R4
    end
  end

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      out_word <= '0; // R9
      out_short <= '0;
    end else if (!rst_b_i) begin
      out_word <= '0;
      out_short <= '0;
    end else if (strobe_d) begin
      out_word <= word_sel; // R11 R6
      out_short <=
        word_sel[`SDF_WORD_WIDTH-1 -: `SDF_OUT_WIDTH]; // R3
    end
  end

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      out_settled <= 1'b0;
    end else if (!rst_b_i) begin
      out_settled <= 1'b0;
    end else if (strobe_d) begin
      out_settled <= (settle_cnt == settle_goal); // R12 R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result carrier, every field straight from its flip-flop
  assign result_o = {out_word, out_short, out_settled, out_valid};

  always_ff @(posedge clk_i or negedge async_reset_low_i) begin
    if (!async_reset_low_i) begin
      settle_cnt <= '0;
    end else if (!rst_b_i) begin
      settle_cnt <= '0;
    end else if (strobe_d && settle_cnt != settle_goal) begin
      settle_cnt <= settle_cnt + 1'b1; // R12
    end
  end

  assign decimation_strobe_o = decimation_strobe;
endmodule

// File: bench/sdf_mod_model.sv
// Modulator stand-in: ones density is level_i over 256.
// Assumes clk_i is the modulator clock shared with the filter.
`timescale 1ns/1ps
module sdf_mod_model (
  input wire logic clk_i,
  input wire logic [7:0] level_i,
  output logic bit_o = 1'b0
);
  logic [7:0] acc = 8'h00;
  // Bit moves on the falling edge, carry spreads the ones
  always @(negedge clk_i) begin
    {bit_o, acc} <= acc + level_i;
  end
endmodule

// File: bench/sdf_checker.sv
// Port checker for the sinc filter.
// Assumes it is bound onto sdf_filter.
`timescale 1ns/1ps
`include "sdf_defines.svh"
module sdf_checker #(
  parameter int RATIO = 256
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic async_reset_low_i,
  input wire logic modulator_bit_in_i,
  input wire logic fast_mode_i,
  input wire logic [`SDF_RATIO_CNT_WIDTH-1:0] oversampling_ratio_i,
  input wire sdf_pkg::sdf_result_type result_o,
  input wire logic decimation_strobe_o
);
  wire logic on = rst_b_i && async_reset_low_i;
  wire logic st = decimation_strobe_o;
  wire logic vl = result_o.valid;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!on);
  AST_LAG: assert property (st |-> ##2 vl) else $error("late");
  AST_CAUSE: assert property (vl |-> $past(st, 2)) else $error("cause");
  AST_PULSE: assert property (vl |=> !vl) else $error("pulse");
  AST_GAP: assert property (st |=> !st [*8]) else $error("gap");
  AST_PAIR: assert property (vl |-> result_o.short_word ==
    result_o.filtered_word[23:8]) else $error("pair");
  AST_P16: assert property (st && oversampling_ratio_i == 9'h010
    |-> ##16 st) else $error("p16");
  AST_P256: assert property (st && oversampling_ratio_i == 9'h100
    |-> ##256 st) else $error("p256");
  AST_HOLD: assert property (!vl |-> $stable(result_o.filtered_word))
    else $error("hold");
  AST_SETTLE: assert property ($rose(result_o.settled) |-> vl)
    else $error("settle");
  AST_CLEAR: assert property (disable iff (1'b0) !async_reset_low_i
    |-> result_o == '0 && !st) else $error("clear");
  AST_SYNC: assert property (disable iff (1'b0) !rst_b_i
    |=> result_o == '0) else $error("sync");
endmodule
bind sdf_filter sdf_checker #(.RATIO(RATIO)) chk_u (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .async_reset_low_i(async_reset_low_i),
  .modulator_bit_in_i(modulator_bit_in_i), .fast_mode_i(fast_mode_i),
  .oversampling_ratio_i(oversampling_ratio_i), .result_o(result_o),
  .decimation_strobe_o(decimation_strobe_o));

// File: bench/sdf_filter_tb.sv
// Bench for the sinc filter: reference sums run beside the design.
// Assumes the modulator model and the bound checker.
`timescale 1ns/1ps
module sdf_filter_tb;
  logic clk_i = 1'b0;
  logic rst_b = 1'b0;
  logic arst_b = 1'b1;
  logic [8:0] ratio = 9'h010;
  logic [7:0] level = 8'h80;
  logic fast = 1'b0;
  logic bit_w, strobe;
  logic [1:0] sp;
  sdf_pkg::sdf_result_type res;
  sdf_pkg::sdf_word_type i1, i2, i3, d0, d1, d3, d5, c3, c5, h1, h2;
  int cnt, r, nw, n_fail, comparisons;
  always #20 clk_i = ~clk_i;
  sdf_mod_model mod_u (.clk_i(clk_i), .level_i(level), .bit_o(bit_w));
  sdf_filter #(.RATIO(32)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b),
    .async_reset_low_i(arst_b), .modulator_bit_in_i(bit_w),
    .fast_mode_i(fast), .oversampling_ratio_i(ratio), .result_o(res),
    .decimation_strobe_o(strobe));
  task chk(input sdf_pkg::sdf_word_type s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("Counts: %0d fails of %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    r = (ratio >= 16 && ratio <= 256) ? ratio : 32;
    c5 = fast ? d0 - d1 - d3 + h2 : d0 - d1 - d3 - d5;
    if (!rst_b || !arst_b) begin
      {i1, i2, i3, d0, d1, d3, d5, h1, h2, sp} = '0;
      {cnt, nw} = '0;
    end else begin
      chk(strobe, cnt == r - 1);
      chk(res.valid, sp[1]);
      if (res.valid) begin
        nw++;
        chk(res.filtered_word, c5);
        chk(res.short_word, c5[23:8]);
        chk(res.settled, nw >= 4);
      end
      sp = {sp[0], cnt == r - 1};
      if (cnt == r - 1) begin
        h2 = h1;
        h1 = d0 - d1 - d3;
        c3 = d0 - d1;
        d5 = c3 - d3;
        d3 = c3;
        d1 = d0;
        d0 = fast ? i2 : i3;
      end
      i3 += i2;
      i2 += i1;
      i1 += bit_w;
      cnt = (cnt == r - 1) ? 0 : cnt + 1;
    end
  end
  task wait_words(input int n);
    for (int k = 0; k < 9000 && nw < n; k++) #40;
    if (nw < n) begin
      n_fail++;
      close_out;
    end
  endtask
  task run_case(input logic [8:0] rt, input logic [7:0] lv,
                input logic fm, input int n);
    @(posedge clk_i);
    #1 rst_b = 1'b0;
    ratio = rt;
    level = lv;
    fast = fm;
    repeat (4) @(posedge clk_i);
    #1 rst_b = 1'b1;
    wait_words(n);
  endtask
  task s_mid; run_case(9'h010, 8'h80, 1'b0, 6); endtask
  task s_pos; run_case(9'h100, 8'he4, 1'b0, 5); endtask
  task s_neg; run_case(9'h12c, 8'h1c, 1'b0, 5); endtask
  task s_top; run_case(9'h0ff, 8'hff, 1'b0, 4); endtask
  task s_fast; run_case(9'h008, 8'he4, 1'b1, 6); endtask
  task s_async;
    run_case(9'h010, 8'h80, 1'b0, 2);
    arst_b = 1'b0;
    #1 chk(res.filtered_word, '0);
    chk({res.short_word, res.settled, res.valid, strobe}, '0);
    #39 arst_b = 1'b1;
    wait_words(5);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    s_mid();
    s_pos();
    s_neg();
    s_top();
    s_fast();
    s_async();
    close_out;
  end
endmodule
